// ### src/port_stats_cfg.svh
// constants of the per-port ethernet statistics block
`ifndef PORT_STATS_CFG_SVH
`define PORT_STATS_CFG_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define STAT_WIDTH 32
`define LEN_WIDTH 16
`define NUM_COUNTERS 17
`define COLL_CNT_WIDTH 5

// ----------------------------------------------------------------
// frame and collision limits
// ----------------------------------------------------------------
`define MIN_FRAME_LEN 16'h0040
`define HW_PAUSE_LEN 16'h0040
`define MULTI_COLL_MIN 5'h02
`define MULTI_COLL_MAX 5'h0f
`define EXCESS_COLL 5'h10
`define BCAST_ADDR 48'hffff_ffff_ffff

// ----------------------------------------------------------------
// reset values and thresholds
// ----------------------------------------------------------------
`define STAT_RESET 32'h0000_0000
`define STAT_HALF_BIT 31

`endif

// ### src/port_stats_pkg.sv
// types shared by the per-port ethernet statistics block
package port_stats_pkg;

	// ----------------------------------------------------------------
	// receive outcome, valid in the cycle of rx_done
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] len;
		logic is_data;
		logic addr_hit;
		logic promisc;
		logic fcs_fail;
		logic odd_nibbles;
		logic fcs_fail_trunc;
		logic code_err;
		logic fc_jam_coll;
	} rx_frame_t;

	// ----------------------------------------------------------------
	// transmit outcome, valid in the cycle of tx_done
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] len;
		logic [47:0] dest;
		logic hw_pause;
		logic deferred;
		logic carrier_lost;
		logic underrun;
	} tx_frame_t;

	// ----------------------------------------------------------------
	// counter index within the counter array
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		rx_short_good_count = 5'h00,
		rx_short_bad_count = 5'h01,
		rx_good_byte_count = 5'h02,
		tx_good_count = 5'h03,
		tx_bcast_count = 5'h04,
		tx_mcast_count = 5'h05,
		tx_flowctl_count = 5'h06,
		tx_waited_count = 5'h07,
		collision_event_count = 5'h08,
		tx_one_coll_count = 5'h09,
		tx_many_coll_count = 5'h0a,
		tx_abandoned_coll_count = 5'h0b,
		tx_late_coll_count = 5'h0c,
		tx_starved_count = 5'h0d,
		tx_carrier_lost_count = 5'h0e,
		tx_good_byte_count = 5'h0f,
		size_bin_min_count = 5'h10
	} counter_id_t;

endpackage : port_stats_pkg

// ### src/ethernet_port_statistics.sv
// per-port ethernet statistics counters fed by mac frame outcomes
`timescale 1ns/1ps
`include "port_stats_cfg.svh"

module ethernet_port_statistics (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// receive path events
	input wire logic rx_done,
	input wire port_stats_pkg::rx_frame_t rx_frame,
	input wire logic rx_start,
	input wire logic half_duplex,
	input wire logic flow_active,
	input wire logic [15:0] max_rx_frame_length,
	// transmit path events
	input wire logic tx_coll,
	input wire logic tx_coll_late,
	input wire logic tx_done,
	input wire port_stats_pkg::tx_frame_t tx_frame,
	output logic tx_abort,
	// software side: decrement and threshold flag
	input wire logic dec_valid,
	input wire port_stats_pkg::counter_id_t dec_sel,
	input wire logic [31:0] dec_amount,
	input wire logic stats_irq_enable,
	output logic stats_threshold_irq,
	// counter values
	output logic [`NUM_COUNTERS-1:0][`STAT_WIDTH-1:0] counts
);

	// ----------------------------------------------------------------
	// receive classification
	// ----------------------------------------------------------------

	// crc on even nibbles, alignment when the trimmed check fails
	wire logic rx_crc_err = rx_frame.fcs_fail & ~rx_frame.odd_nibbles;
	wire logic rx_align_err = rx_frame.odd_nibbles & rx_frame.fcs_fail_trunc;
	wire logic rx_any_err = rx_crc_err | rx_align_err | rx_frame.code_err;
	wire logic rx_matched = rx_frame.addr_hit | rx_frame.promisc;
	wire logic rx_short = rx_frame.len < `MIN_FRAME_LEN;
	wire logic rx_in_range = ~rx_short & (rx_frame.len <= max_rx_frame_length);

	// qualified receive outcomes, only in the rx_done cycle
	wire logic rx_short_good = rx_done & rx_frame.is_data & rx_matched & rx_short & ~rx_any_err;
	wire logic rx_short_bad = rx_done & rx_frame.is_data & rx_short & rx_any_err
		& ~rx_frame.fc_jam_coll;
	wire logic rx_good = rx_done & rx_matched & rx_in_range & ~rx_any_err;
	wire logic rx_bin_min = rx_done & (rx_frame.len == `MIN_FRAME_LEN);

	// receive start while jamming for flow control counts as a collision
	wire logic rx_fc_coll = rx_start & half_duplex & flow_active;

	// ----------------------------------------------------------------
	// per-frame transmit collision tracking
	// ----------------------------------------------------------------
	logic [4:0] coll_seen;
	logic late_seen;
	logic aborted;

	// the late flag is sticky until the frame closes, so it dominates
	wire logic coll_normal = tx_coll & ~tx_coll_late & ~aborted;
	wire logic coll_late = tx_coll & tx_coll_late & ~aborted;
	wire logic [4:0] coll_plus = coll_seen + 5'h01;
	wire logic hit_excess = coll_normal & (coll_plus == `EXCESS_COLL);
	wire logic next_abort = hit_excess | coll_late;

	// collisions that arrive with tx_done still belong to that frame
	wire logic [4:0] fin_coll = coll_normal ? coll_plus : coll_seen;
	wire logic fin_late = late_seen | coll_late;
	wire logic fin_excess = fin_coll == `EXCESS_COLL;
	wire logic [4:0] fin_total = fin_coll + {4'h0, fin_late};

	// track collisions of the frame in flight; tx_done closes it
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			coll_seen <= 5'h00;
			late_seen <= 1'b0;
			aborted <= 1'b0;
		end else if (tx_done) begin
			coll_seen <= 5'h00;
			late_seen <= 1'b0;
			aborted <= 1'b0;
		end else begin
			if (coll_normal) begin
				coll_seen <= coll_plus;
			end
			if (coll_late) begin
				late_seen <= 1'b1;
			end
			if (next_abort) begin
				aborted <= 1'b1;
			end
		end
	end

	// one-cycle abandon request to the transmit path
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			tx_abort <= 1'b0;
		end else begin
			tx_abort <= next_abort & ~tx_done;
		end
	end

	// ----------------------------------------------------------------
	// transmit classification at the frame outcome
	// ----------------------------------------------------------------

	// carrier loss does not abort, so such frames simply complete
	wire logic tx_clean = ~tx_frame.carrier_lost & ~tx_frame.underrun;
	wire logic tx_good = tx_done & tx_clean & ~fin_late & ~fin_excess;
	wire logic tx_bcast = tx_frame.dest == `BCAST_ADDR;
	// hardware pause frames are multicast by construction
	wire logic tx_mcast = (tx_frame.dest[40] & ~tx_bcast) | tx_frame.hw_pause;
	wire logic [15:0] tx_len = tx_frame.hw_pause ? `HW_PAUSE_LEN : tx_frame.len;

	wire logic tx_good_bcast = tx_good & tx_bcast & ~tx_frame.hw_pause;
	wire logic tx_good_mcast = tx_good & tx_mcast;
	wire logic tx_pause = tx_done & tx_frame.hw_pause;
	wire logic tx_waited = tx_done & tx_frame.deferred & tx_clean & (fin_total == 5'h00);
	wire logic tx_coll_ok = tx_done & tx_clean;
	// late collision frames never reach the three classes below
	wire logic tx_one = tx_good & (fin_coll == 5'h01);
	wire logic tx_many = tx_good & (fin_coll >= `MULTI_COLL_MIN)
		& (fin_coll <= `MULTI_COLL_MAX);
	wire logic tx_excess = tx_done & tx_clean & fin_excess & ~fin_late;
	wire logic tx_late = tx_done & fin_late;
	wire logic tx_starved = tx_done & tx_frame.underrun;
	wire logic tx_carrier = tx_done & tx_frame.carrier_lost;
	wire logic tx_bin_min = tx_done & (tx_len == `MIN_FRAME_LEN)
		& ~fin_late & ~fin_excess;

	// ----------------------------------------------------------------
	// increments per counter, applied all in one update
	// ----------------------------------------------------------------
	logic [`STAT_WIDTH-1:0] inc [`NUM_COUNTERS];
	wire logic [4:0] coll_add = (tx_coll_ok ? fin_total : 5'h00) + {4'h0, rx_fc_coll};
	wire logic [1:0] bin_add = {1'b0, rx_bin_min} + {1'b0, tx_bin_min};

	// a frame may bump several counters in the same cycle
	always_comb begin
		for (int k = 0; k < `NUM_COUNTERS; k++) begin
			inc[k] = 32'h0000_0000;
		end
		inc[port_stats_pkg::rx_short_good_count] = {31'h0, rx_short_good};
		inc[port_stats_pkg::rx_short_bad_count] = {31'h0, rx_short_bad};
		inc[port_stats_pkg::rx_good_byte_count] = rx_good ? {16'h0000, rx_frame.len} : 32'h0;
		inc[port_stats_pkg::tx_good_count] = {31'h0, tx_good};
		inc[port_stats_pkg::tx_bcast_count] = {31'h0, tx_good_bcast};
		inc[port_stats_pkg::tx_mcast_count] = {31'h0, tx_good_mcast};
		inc[port_stats_pkg::tx_flowctl_count] = {31'h0, tx_pause};
		inc[port_stats_pkg::tx_waited_count] = {31'h0, tx_waited};
		inc[port_stats_pkg::collision_event_count] = {27'h0, coll_add};
		inc[port_stats_pkg::tx_one_coll_count] = {31'h0, tx_one};
		inc[port_stats_pkg::tx_many_coll_count] = {31'h0, tx_many};
		inc[port_stats_pkg::tx_abandoned_coll_count] = {31'h0, tx_excess};
		inc[port_stats_pkg::tx_late_coll_count] = {31'h0, tx_late};
		inc[port_stats_pkg::tx_starved_count] = {31'h0, tx_starved};
		inc[port_stats_pkg::tx_carrier_lost_count] = {31'h0, tx_carrier};
		inc[port_stats_pkg::tx_good_byte_count] = tx_good ? {16'h0000, tx_len} : 32'h0;
		inc[port_stats_pkg::size_bin_min_count] = {30'h0, bin_add};
	end

	// ----------------------------------------------------------------
	// counter storage
	// ----------------------------------------------------------------
	logic [`NUM_COUNTERS-1:0] half_hit;

	// modulo arithmetic wraps all ones to zero; a software decrement
	// in the same cycle as an increment applies both
	genvar g;
	generate
		for (g = 0; g < `NUM_COUNTERS; g++) begin : gen_count
			wire logic dec_hit = dec_valid & (dec_sel == 5'(g));
			wire logic [31:0] dec_val = dec_hit ? dec_amount : 32'h0000_0000;
			wire logic [31:0] next_count = counts[g] + inc[g] - dec_val;

			always_ff @(posedge mclk or posedge reset) begin
				if (reset) begin
					counts[g] <= `STAT_RESET;
				end else begin
					counts[g] <= next_count;
				end
			end

			assign half_hit[g] = next_count[`STAT_HALF_BIT];
		end
	endgenerate

	// ----------------------------------------------------------------
	// half-scale flag
	// ----------------------------------------------------------------

	// follows the new counter values so it tracks them in the same edge
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stats_threshold_irq <= 1'b0;
		end else begin
			stats_threshold_irq <= stats_irq_enable & (|half_hit);
		end
	end

endmodule : ethernet_port_statistics

// ### tb/port_stats_props.sv
// concurrent checks on the port statistics counter outputs
`timescale 1ns/1ps
module port_stats_props (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// frame events
	input wire logic rx_done,
	input wire port_stats_pkg::rx_frame_t rx_frame,
	input wire logic rx_start,
	input wire logic [15:0] max_rx_frame_length,
	input wire logic tx_coll,
	input wire logic tx_done,
	input wire port_stats_pkg::tx_frame_t tx_frame,
	input wire logic tx_abort,
	// software side and results
	input wire logic dec_valid,
	input wire port_stats_pkg::counter_id_t dec_sel,
	input wire logic [31:0] dec_amount,
	input wire logic stats_irq_enable,
	input wire logic stats_threshold_irq,
	input wire logic [16:0][31:0] counts
);
	logic aborted;
	logic any_half;
	// qualifiers kept strict so no legal mix of events can trip a check
	wire quiet = !rx_done && !tx_done && !rx_start && !dec_valid;
	wire rx_ok = (rx_frame.addr_hit || rx_frame.promisc) && !rx_frame.fcs_fail
		&& !rx_frame.fcs_fail_trunc && !rx_frame.code_err && !dec_valid;
	wire tx_ok = !tx_frame.carrier_lost && !tx_frame.underrun && !tx_frame.hw_pause
		&& !tx_coll && !aborted && !tx_abort && !dec_valid;
	// any counter at half scale
	always_comb begin
		any_half = 1'b0;
		for (int i = 0; i < 17; i++) any_half = any_half | counts[i][31];
	end
	// remembers an abort until its frame closes
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) aborted <= 1'b0;
		else if (tx_done) aborted <= 1'b0;
		else if (tx_abort) aborted <= 1'b1;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	a_counts_hold_still: assert property (quiet |=> $stable(counts))
		else $error("counter changed without an event");
	a_rx_good_bytes: assert property (rx_done && rx_ok && rx_frame.len >= 16'h0040
		&& rx_frame.len <= max_rx_frame_length
		|=> counts[2] == $past(counts[2]) + 32'($past(rx_frame.len)))
		else $error("receive byte count off");
	a_rx_fragment_count: assert property (rx_done && rx_frame.is_data && rx_frame.code_err
		&& rx_frame.len < 16'h0040 && !rx_frame.fc_jam_coll && !dec_valid
		|=> counts[1] == $past(counts[1]) + 32'h1)
		else $error("fragment count off");
	a_tx_good_bytes: assert property (tx_done && tx_ok
		|=> counts[15] == $past(counts[15]) + 32'($past(tx_frame.len)))
		else $error("transmit byte count off");
	a_carrier_lost_count: assert property (tx_done && tx_frame.carrier_lost && !dec_valid
		|=> counts[14] == $past(counts[14]) + 32'h1)
		else $error("carrier loss count off");
	a_dec_applies: assert property (dec_valid && !rx_done && !tx_done && !rx_start
		|=> counts[$past(dec_sel)] == $past(counts[dec_sel]) - $past(dec_amount))
		else $error("decrement not applied");
	a_irq_follows: assert property (1'b1
		|=> stats_threshold_irq == ($past(stats_irq_enable) && any_half))
		else $error("threshold flag wrong");
	a_abort_cause: assert property ($rose(tx_abort) |-> $past(tx_coll))
		else $error("abort without a collision");
	a_abort_single: assert property (tx_abort |=> !tx_abort)
		else $error("abort longer than one cycle");
endmodule : port_stats_props

bind ethernet_port_statistics port_stats_props chk (.mclk(mclk), .reset(reset),
	.rx_done(rx_done), .rx_frame(rx_frame), .rx_start(rx_start), .tx_coll(tx_coll),
	.max_rx_frame_length(max_rx_frame_length), .tx_done(tx_done), .tx_frame(tx_frame),
	.tx_abort(tx_abort), .dec_valid(dec_valid), .dec_sel(dec_sel), .dec_amount(dec_amount),
	.stats_irq_enable(stats_irq_enable), .stats_threshold_irq(stats_threshold_irq),
	.counts(counts));

// ### tb/mac_event_model.sv
// mac receive and transmit paths handing frame outcomes to the counters
`timescale 1ns/1ps
module mac_event_model (
	// clock
	input wire logic mclk,
	// frame events
	output logic rx_done,
	output port_stats_pkg::rx_frame_t rx_frame,
	output logic rx_start,
	output logic tx_coll,
	output logic tx_coll_late,
	output logic tx_done,
	output port_stats_pkg::tx_frame_t tx_frame
);
	// idle fields are scrambled so stale values never look valid
	initial begin
		rx_done = 1'b0;
		rx_start = 1'b0;
		tx_coll = 1'b0;
		tx_coll_late = 1'b1;
		tx_done = 1'b0;
		rx_frame = '1;
		tx_frame = '1;
	end
	// one outcome pulse per received frame
	task automatic rx(input port_stats_pkg::rx_frame_t f);
		@(posedge mclk) #1;
		rx_done = 1'b1;
		rx_frame = f;
		@(posedge mclk) #1;
		rx_done = 1'b0;
		rx_frame = ~f;
	endtask : rx
	// n early collisions, optionally a late one, then the outcome
	task automatic tx(input port_stats_pkg::tx_frame_t f, input int n, input logic late);
		for (int i = 0; i < n + late; i++) begin
			@(posedge mclk) #1;
			tx_coll = 1'b1;
			tx_coll_late = late && i == n;
		end
		@(posedge mclk) #1;
		tx_coll = 1'b0;
		@(posedge mclk) #1;
		tx_done = 1'b1;
		tx_frame = f;
		@(posedge mclk) #1;
		tx_done = 1'b0;
		tx_frame = ~f;
	endtask : tx
	// start of a reception
	task automatic start();
		@(posedge mclk) #1;
		rx_start = 1'b1;
		@(posedge mclk) #1;
		rx_start = 1'b0;
	endtask : start
endmodule : mac_event_model

// ### tb/ethernet_port_statistics_test.sv
// self-checking bench for the port statistics counters
`timescale 1ns/1ps
module ethernet_port_statistics_test;
	logic mclk, reset, half_duplex, flow_active, tx_coll, tx_coll_late, tx_done, rx_done;
	logic rx_start, dec_valid, stats_irq_enable, tx_abort, irq, seen_abort;
	logic [31:0] dec_amount;
	logic [15:0] max_len;
	port_stats_pkg::counter_id_t dec_sel;
	port_stats_pkg::rx_frame_t rx_frame;
	port_stats_pkg::tx_frame_t tx_frame;
	logic [16:0][31:0] counts, exp;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	localparam logic [47:0] uc = 48'h0200_0000_0001;
	mac_event_model mac (.mclk(mclk), .rx_done(rx_done), .rx_frame(rx_frame),
		.rx_start(rx_start), .tx_coll(tx_coll), .tx_coll_late(tx_coll_late),
		.tx_done(tx_done), .tx_frame(tx_frame));
	ethernet_port_statistics dut (.mclk(mclk), .reset(reset), .rx_done(rx_done),
		.rx_frame(rx_frame), .rx_start(rx_start), .half_duplex(half_duplex),
		.flow_active(flow_active), .max_rx_frame_length(max_len), .tx_coll(tx_coll),
		.tx_coll_late(tx_coll_late), .tx_done(tx_done), .tx_frame(tx_frame),
		.tx_abort(tx_abort), .dec_valid(dec_valid), .dec_sel(dec_sel),
		.dec_amount(dec_amount), .stats_irq_enable(stats_irq_enable),
		.stats_threshold_irq(irq), .counts(counts));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// abort watch and hang ceiling, far above the roughly 125 cycles needed
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (tx_abort) seen_abort <= 1'b1;
		if (cycles == 5000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp
	task automatic all_counts();
		for (int i = 0; i < 17; i++) cmp(counts[i], exp[i]);
	endtask : all_counts
	// receive frame with its expected counter effects
	task automatic send_rx(input port_stats_pkg::rx_frame_t f);
		logic err, hit, sh;
		err = (f.fcs_fail && !f.odd_nibbles) || (f.odd_nibbles && f.fcs_fail_trunc) || f.code_err;
		hit = f.addr_hit || f.promisc;
		sh = f.len < 16'h0040;
		mac.rx(f);
		exp[0] += 32'(f.is_data && sh && hit && !err);
		exp[1] += 32'(f.is_data && sh && err && !f.fc_jam_coll);
		if (hit && !sh && f.len <= max_len && !err) exp[2] += 32'(f.len);
		exp[16] += 32'(f.len == 16'h0040);
		all_counts();
	endtask : send_rx
	// transmit frame; pause frames count as 64-byte multicast
	task automatic send_tx(input port_stats_pkg::tx_frame_t f, input int n, input logic late);
		logic cl, ab, bc;
		logic [15:0] len;
		cl = !f.carrier_lost && !f.underrun;
		ab = late || n >= 16;
		len = f.hw_pause ? 16'h0040 : f.len;
		bc = f.dest == 48'hffff_ffff_ffff && !f.hw_pause;
		seen_abort = 1'b0;
		mac.tx(f, n, late);
		if (cl) exp[8] += 32'(n + late);
		if (cl && !ab) exp[3] += 32'h1;
		if (cl && !ab) exp[15] += 32'(len);
		exp[4] += 32'(cl && !ab && bc);
		exp[5] += 32'(cl && !ab && !bc && (f.hw_pause || f.dest[40]));
		exp[6] += 32'(f.hw_pause);
		exp[7] += 32'(f.deferred && n == 0 && !late && cl);
		exp[9] += 32'(cl && !late && n == 1);
		exp[10] += 32'(cl && !late && n > 1 && n < 16);
		exp[11] += 32'(cl && !late && n == 16);
		exp[12] += 32'(late);
		exp[13] += 32'(f.underrun);
		exp[14] += 32'(f.carrier_lost);
		exp[16] += 32'(len == 16'h0040 && !ab);
		all_counts();
		cmp(32'(seen_abort), 32'(ab));
	endtask : send_tx
	task automatic test_rx();
		send_rx('{16'h003f, 1, 1, 0, 0, 0, 0, 0, 0});
		send_rx('{16'h003f, 0, 0, 1, 0, 0, 0, 0, 0});
		send_rx('{16'h0030, 1, 0, 0, 1, 0, 0, 0, 0});
		send_rx('{16'h0020, 1, 0, 0, 0, 0, 0, 1, 1});
		send_rx('{16'h0064, 0, 1, 0, 0, 0, 0, 0, 0});
		send_rx('{16'h0065, 1, 1, 0, 0, 0, 0, 0, 0});
		send_rx('{16'h0041, 1, 1, 0, 1, 1, 0, 0, 0});
		send_rx('{16'h0040, 1, 1, 0, 1, 1, 1, 0, 0});
	endtask : test_rx
	task automatic test_tx();
		send_tx('{16'h00c8, 48'hffff_ffff_ffff, 0, 0, 0, 0}, 0, 0);
		send_tx('{16'h0050, 48'h0100_0000_0001, 0, 0, 0, 0}, 0, 0);
		send_tx('{16'h0000, uc, 1, 0, 0, 0}, 0, 0);
		send_tx('{16'h0050, uc, 0, 1, 0, 0}, 0, 0);
		send_tx('{16'h0050, uc, 0, 1, 0, 0}, 1, 0);
		send_tx('{16'h0051, uc, 0, 0, 0, 0}, 2, 0);
		send_tx('{16'h0052, uc, 0, 0, 0, 0}, 15, 0);
		send_tx('{16'h0053, uc, 0, 0, 0, 0}, 16, 0);
		send_tx('{16'h0054, uc, 0, 0, 0, 0}, 15, 1);
		send_tx('{16'h0040, uc, 0, 0, 1, 0}, 2, 0);
		send_tx('{16'h0055, uc, 0, 0, 0, 1}, 0, 0);
	endtask : test_tx
	// flow-control receive starts, then decrement wrap and threshold flag
	task automatic test_misc();
		half_duplex = 1'b1;
		mac.start();
		exp[8] += 32'h1;
		half_duplex = 1'b0;
		mac.start();
		half_duplex = 1'b1;
		flow_active = 1'b0;
		mac.start();
		half_duplex = 1'b0;
		flow_active = 1'b1;
		all_counts();
		dec_valid = 1'b1;
		dec_sel = port_stats_pkg::tx_good_count;
		dec_amount = exp[3] + 32'h1;
		@(posedge mclk) #1;
		dec_valid = 1'b0;
		exp[3] = 32'hffff_ffff;
		all_counts();
		cmp(32'(irq), 32'h0);
		stats_irq_enable = 1'b1;
		@(posedge mclk) #1;
		cmp(32'(irq), 32'h1);
		send_tx('{16'h0050, uc, 0, 0, 0, 0}, 0, 0);
		cmp(32'(irq), 32'h0);
	endtask : test_misc
	task automatic end_sim();
		if (miscompares == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_sim
	initial begin
		reset = 1'b1;
		{half_duplex, dec_valid, stats_irq_enable, seen_abort} = 4'h0;
		flow_active = 1'b1;
		dec_sel = port_stats_pkg::rx_short_good_count;
		dec_amount = 32'h0000_0000;
		max_len = 16'h0064;
		exp = '0;
		repeat (12) @(posedge mclk);
		#1 reset = 1'b0;
		test_rx();
		test_tx();
		test_misc();
		end_sim();
	end
endmodule : ethernet_port_statistics_test
